// >>> logic/i2c_master_receive_ack.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Reset or disable clears start/stop seen
// - Bus may be taken only when free
// - Hardware alone drives clock and data lines
// - Interrupt flag on start, stop, byte, ack
// - Stop while busy raises interrupt: bus free
// - Data line mismatch sets bus collision flag
// - Receive enable ignored unless module idle
// - Baud rollovers toggle clock, shift data in
// - Eighth falling edge: load buffer, flag, idle
// - Buffer full set on load, cleared on read
// - Byte received while buffer full: overflow
// - Buffer write during receive: collision, discarded
// - Ack enable: clock low, ack value driven
// - Ack: release, wait high, count, pull low
// - Buffer write during ack: collision, discarded
module i2c_master_receive_ack
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe_n,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n,
   output logic             irq
);
   import i2c_rx_pkg::*;

   master_state_t state;
   logic [1:0]    scl_sync, sda_sync;
   logic [2:0]    bit_index;
   logic [3:0]    irq_status, irq_mask, irq_set;
   logic [7:0]    baud_period, baud_count, receive_shift_register, transfer_buffer;
   logic [31:0]   next_prdata;
   logic          module_enable, receive_enable_bit, ack_sequence_enable, ack_value_bit, sda_prev;
   logic          scl_hold_low, sda_hold_low, buffer_full_flag, start_seen, stop_seen, busy;
   logic          baud_tick, baud_run, byte_done, ack_done, wr_access, rd_access;
   logic          start_event, stop_event, collision_event, write_collision;
   // Word address hit test, shared by read and write decode
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
      hit = (addr == offset);
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Two stages before any logic looks at the lines
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         sda_prev <= 1'b1;
      end
      else
      begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
         sda_prev <= sda_sync[1];
      end
   end

   // Bus conditions: data edge while clock high
   assign start_event = scl_sync[1] && sda_prev && !sda_sync[1];
   assign stop_event  = scl_sync[1] && !sda_prev && sda_sync[1];

   // ----------------------------------------------------------------
   // Start / stop tracking
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         start_seen <= 1'b0;
         stop_seen  <= 1'b0;
      end
      else if (!module_enable)
      begin
         start_seen <= 1'b0;
         stop_seen  <= 1'b0;
      end
      else if (start_event)
      begin
         start_seen <= 1'b1;
         stop_seen  <= 1'b0;
      end
      else if (stop_event)
      begin
         start_seen <= 1'b0;
         stop_seen  <= 1'b1;
      end
   end

   // Software may claim the bus only while this reads zero
   assign busy = !(stop_seen || (!start_seen && !stop_seen));

   // ----------------------------------------------------------------
   // Baud rate generator
   // ----------------------------------------------------------------
   // Counting restarts from the full period while a released clock still reads low: stretching for free
   assign baud_run  = (state != ST_IDLE) && !(!scl_hold_low && !scl_sync[1]);
   assign baud_tick = baud_run && (baud_count == 8'h00);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         baud_count <= RESET_BAUD;
      else if (!baud_run || baud_tick)
         baud_count <= baud_period - 8'h01;
      else
         baud_count <= baud_count - 8'h01;
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   assign byte_done = (state == ST_RECEIVE) && baud_tick && !scl_hold_low
                      && (bit_index == LAST_BIT_INDEX);
   assign ack_done  = (state == ST_ACK_HIGH) && baud_tick;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state                  <= ST_IDLE;
         scl_hold_low           <= 1'b0;
         sda_hold_low           <= 1'b0;
         bit_index              <= 3'h0;
         receive_shift_register <= 8'h00;
      end
      else if (!module_enable)
      begin
         state        <= ST_IDLE;
         scl_hold_low <= 1'b0;
         sda_hold_low <= 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               bit_index <= 3'h0;
               if (receive_enable_bit)
               begin
                  state        <= ST_RECEIVE;
                  scl_hold_low <= 1'b1;
                  sda_hold_low <= 1'b0;  // Slave owns the data line
               end
               else if (ack_sequence_enable)
               begin
                  state        <= ST_ACK_LOW;
                  scl_hold_low <= 1'b1;
                  sda_hold_low <= !ack_value_bit;
               end
            end
            ST_RECEIVE:
            begin
               if (baud_tick)
               begin
                  if (scl_hold_low)
                     scl_hold_low <= 1'b0;
                  else
                  begin
                     // Sample just before the falling edge
                     receive_shift_register <= {receive_shift_register[6:0], sda_sync[1]};
                     scl_hold_low <= 1'b1;
                     bit_index    <= bit_index + 3'h1;
                     if (bit_index == LAST_BIT_INDEX)
                        state <= ST_IDLE;
                  end
               end
            end
            ST_ACK_LOW:
            begin
               if (baud_tick)
               begin
                  scl_hold_low <= 1'b0;
                  state        <= ST_ACK_HIGH;
               end
            end
            ST_ACK_HIGH:
            begin
               // Counter only runs once the clock is seen high
               if (baud_tick)
               begin
                  scl_hold_low <= 1'b1;
                  sda_hold_low <= 1'b0;
                  state        <= ST_IDLE;
               end
            end
            default:
            begin
               state        <= ST_IDLE;
               scl_hold_low <= 1'b0;
               sda_hold_low <= 1'b0;
            end
         endcase
      end
   end

   // Open-drain drive: only ever pull low, never drive high
   assign scl_out  = 1'b0;
   assign sda_out  = 1'b0;
   assign scl_oe_n = !scl_hold_low;
   assign sda_oe_n = !sda_hold_low;

   // Released data line read low while clock high means lost arbitration
   assign collision_event = (state != ST_IDLE) && (state != ST_RECEIVE)
                            && !sda_hold_low && scl_sync[1] && !sda_sync[1];

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign wr_access       = psel && penable && pwrite;
   assign rd_access       = psel && penable && !pwrite;
   assign pready          = 1'b1;
   assign pslverr         = psel && penable && ((paddr[1:0] != 2'h0) || (paddr > ADDR_IRQ_MASK));
   assign write_collision = wr_access && hit(paddr, ADDR_BUFFER) && (state != ST_IDLE);

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         module_enable <= 1'b0;
         baud_period   <= RESET_BAUD;
         ack_value_bit <= 1'b0;
         irq_mask      <= RESET_MASK;
      end
      else if (wr_access)
      begin
         if (hit(paddr, ADDR_CONFIG))
            module_enable <= pwdata[BIT_MODULE_ENABLE];
         if (hit(paddr, ADDR_BAUD))
            baud_period <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];  // Zero would wrap the reload to 255, a 256-cycle period
         if (hit(paddr, ADDR_CONTROL_TWO))
            ack_value_bit <= pwdata[BIT_ACK_VALUE];
         if (hit(paddr, ADDR_IRQ_MASK))
            irq_mask <= pwdata[3:0];
      end
   end

   // Start bits: accepted only from idle, cleared by the sequencer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         receive_enable_bit  <= 1'b0;
         ack_sequence_enable <= 1'b0;
      end
      else if (!module_enable || byte_done || ack_done)
      begin
         receive_enable_bit  <= 1'b0;
         ack_sequence_enable <= 1'b0;
      end
      else if (wr_access && hit(paddr, ADDR_CONTROL_TWO) && (state == ST_IDLE)
               && !receive_enable_bit && !ack_sequence_enable)
      begin
         receive_enable_bit  <= pwdata[BIT_RECEIVE_EN];
         ack_sequence_enable <= pwdata[BIT_ACK_SEQ_EN] && !pwdata[BIT_RECEIVE_EN];
      end
   end

   // ----------------------------------------------------------------
   // Transfer buffer and buffer-full flag
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         transfer_buffer <= 8'h00;
      else if (byte_done)
         transfer_buffer <= {receive_shift_register[6:0], sda_sync[1]};
      else if (wr_access && hit(paddr, ADDR_BUFFER) && !write_collision)
         transfer_buffer <= pwdata[7:0];
   end

   // Set wins over the read that clears it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         buffer_full_flag <= 1'b0;
      else if (byte_done)
         buffer_full_flag <= 1'b1;
      else if (rd_access && hit(paddr, ADDR_BUFFER))
         buffer_full_flag <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Interrupt status, write one to clear
   // ----------------------------------------------------------------
   always_comb
   begin
      irq_set                    = 4'h0;
      irq_set[BIT_IRQ_SERIAL]    = byte_done || ack_done || (module_enable && (start_event || stop_event));
      irq_set[BIT_IRQ_BUS_COLL]  = collision_event;
      irq_set[BIT_IRQ_WRITE_COL] = write_collision;
      irq_set[BIT_IRQ_OVERFLOW]  = byte_done && buffer_full_flag;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_status <= 4'h0;
      else if (wr_access && hit(paddr, ADDR_IRQ_STATUS))
         irq_status <= (irq_status & ~pwdata[3:0]) | irq_set;  // A new event is never lost to the clear
      else
         irq_status <= irq_status | irq_set;
   end

   assign irq = |(irq_status & irq_mask);

   // ----------------------------------------------------------------
   // Read data, registered in the setup phase
   // ----------------------------------------------------------------
   always_comb
   begin
      next_prdata = 32'h0000_0000;
      if (hit(paddr, ADDR_CONFIG))
         next_prdata[BIT_MODULE_ENABLE] = module_enable;
      if (hit(paddr, ADDR_CONTROL_TWO))
      begin
         next_prdata[BIT_RECEIVE_EN] = receive_enable_bit;
         next_prdata[BIT_ACK_SEQ_EN] = ack_sequence_enable;
         next_prdata[BIT_ACK_VALUE]  = ack_value_bit;
      end
      if (hit(paddr, ADDR_BAUD))
         next_prdata[7:0] = baud_period;
      if (hit(paddr, ADDR_STATUS))
      begin
         next_prdata[BIT_BUFFER_FULL] = buffer_full_flag;
         next_prdata[BIT_START_SEEN]  = start_seen;
         next_prdata[BIT_STOP_SEEN]   = stop_seen;
         next_prdata[BIT_BUS_FREE]    = !busy;
      end
      if (hit(paddr, ADDR_BUFFER))
         next_prdata[7:0] = transfer_buffer;
      if (hit(paddr, ADDR_IRQ_STATUS))
         next_prdata[3:0] = irq_status;
      if (hit(paddr, ADDR_IRQ_MASK))
         next_prdata[3:0] = irq_mask;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable)
         prdata <= next_prdata;
   end

endmodule

// >>> logic/i2c_rx_pkg.sv
package i2c_rx_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CONFIG      = 8'h00;
   localparam logic [7:0] ADDR_CONTROL_TWO = 8'h04;
   localparam logic [7:0] ADDR_BAUD        = 8'h08;
   localparam logic [7:0] ADDR_STATUS      = 8'h0C;
   localparam logic [7:0] ADDR_BUFFER      = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h14;
   localparam logic [7:0] ADDR_IRQ_MASK    = 8'h18;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_MODULE_ENABLE = 0;
   localparam int BIT_RECEIVE_EN    = 3;
   localparam int BIT_ACK_SEQ_EN    = 4;
   localparam int BIT_ACK_VALUE     = 5;
   localparam int BIT_BUFFER_FULL   = 0;
   localparam int BIT_START_SEEN    = 1;
   localparam int BIT_STOP_SEEN     = 2;
   localparam int BIT_BUS_FREE      = 3;
   localparam int BIT_IRQ_SERIAL    = 0;
   localparam int BIT_IRQ_BUS_COLL  = 1;
   localparam int BIT_IRQ_WRITE_COL = 2;
   localparam int BIT_IRQ_OVERFLOW  = 3;

   // ----------------------------------------------------------------
   // Reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0] RESET_BAUD    = 8'h0A;
   localparam logic [3:0] RESET_MASK    = 4'h0;
   localparam logic [2:0] LAST_BIT_INDEX = 3'h7;

   typedef enum logic [4:0] {
      ST_IDLE      = 5'b00001,
      ST_RECEIVE   = 5'b00010,
      ST_ACK_LOW   = 5'b00100,
      ST_ACK_HIGH  = 5'b01000,
      ST_SPARE     = 5'b10000
   } master_state_t;

endpackage

// >>> dv/i2c_rx_chk.sv
`timescale 1ns/100ps
module i2c_rx_chk
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        scl_in,
   input wire logic        scl_out,
   input wire logic        scl_oe_n,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe_n,
   input wire logic        irq
);
   import i2c_rx_pkg::*;
   logic [7:0] baud;
   logic [7:0] hi_cnt;
   logic [3:0] mask;
   logic       armed;
   logic       wr_acc;
   assign wr_acc = psel && penable && pwrite;

   // Shadow copies of baud and mask, taken from completed writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         baud <= RESET_BAUD;
         mask <= RESET_MASK;
      end
      else if (wr_acc && paddr == ADDR_BAUD)
         baud <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
      else if (wr_acc && paddr == ADDR_IRQ_MASK)
         mask <= pwdata[3:0];
   end

   // High-phase length; the long idle release before the first byte is skipped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hi_cnt <= 8'h00;
         armed  <= 1'b0;
      end
      else
      begin
         hi_cnt <= (scl_oe_n && scl_in) ? hi_cnt + 8'h01 : 8'h00;
         if (!scl_oe_n)
            armed <= 1'b1;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   reset_release_a: assert property ($rose(presetn) |-> scl_oe_n && sda_oe_n && !irq)
      else $error("lines or irq active after reset");
   open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
      else $error("line driven high");
   baud_high_a: assert property ($fell(scl_oe_n) && armed |-> hi_cnt + 8'h01 >= baud && hi_cnt <= baud + 8'h04)
      else $error("clock high phase length wrong");
   ack_clock_low_a: assert property ($fell(sda_oe_n) |-> !scl_oe_n)
      else $error("ack driven while clock released");
   sda_release_a: assert property ($rose(sda_oe_n) |-> !scl_oe_n)
      else $error("data released while clock high");
   sda_steady_a: assert property (scl_in && $past(scl_in) && scl_oe_n |-> $stable(sda_oe_n))
      else $error("data changed while clock high");
   irq_level_a: assert property (psel && penable && !pwrite && paddr == ADDR_IRQ_STATUS
      |-> irq == |(prdata[3:0] & mask))
      else $error("irq disagrees with status and mask");
   irq_mask_a: assert property (mask == 4'h0 |-> !irq)
      else $error("irq high while fully masked");

   cover property ($rose(irq));
   cover property ($fell(sda_oe_n));
   cover property ($fell(scl_oe_n) && armed);
endmodule

bind i2c_master_receive_ack i2c_rx_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));

// >>> dv/i2c_slave_model.sv
`timescale 1ns/100ps
module i2c_slave_model
(
   input  wire logic       scl,
   input  wire logic       arm,
   input  wire logic [7:0] tx_byte,
   input  wire logic       stretch,
   output logic            sda_pull,
   output logic            scl_pull
);
   logic [3:0] edge_cnt;
   initial edge_cnt = 4'hF;

   // New bit after each falling clock, MSB first; line freed after the last bit
   always @(negedge scl or posedge arm)
   begin
      // A clock already held low by the master will not fall again before bit 7
      if (arm)
         edge_cnt <= scl ? 4'h0 : 4'h1;
      else if (edge_cnt != 4'hF)
         edge_cnt <= edge_cnt + 4'h1;
   end

   assign sda_pull = (edge_cnt >= 4'h1 && edge_cnt <= 4'h8) ? !tx_byte[4'h8 - edge_cnt] : 1'b0;
   assign scl_pull = stretch; // Clock stretching, as the bench commands
endmodule

// >>> dv/i2c_master_receive_ack_bench.sv
`timescale 1ns/100ps
module i2c_master_receive_ack_bench;
   import i2c_rx_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n, irq;
   logic        scl, sda, m_scl, m_sda, t_sda, arm, stretch, rerr;
   logic [7:0]  tx_byte;
   logic [31:0] rdata;
   int          errors, cmp_count, cycles;

   // Open-drain wires with pull-ups: any party pulling low wins
   assign scl = !(!scl_oe_n || m_scl);
   assign sda = !(!sda_oe_n || m_sda || t_sda);

   i2c_master_receive_ack i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));
   i2c_slave_model i_slave (.scl(scl), .arm(arm), .tx_byte(tx_byte), .stretch(stretch),
      .sda_pull(m_sda), .scl_pull(m_scl));

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; waits for pready rather than assuming zero wait states
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(name, rdata, exp);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 2000)
      begin
         @(posedge pclk);
         n++;
      end
      check("irq arrives", {31'h0, irq}, 32'h1);
   endtask

   // Slave is armed before the command so that its first bit is ready
   task automatic start_rx(input logic [7:0] b);
      tx_byte <= b;
      arm     <= 1'b1;
      @(posedge pclk);
      arm <= 1'b0;
      wr(ADDR_CONTROL_TWO, 32'h8);
   endtask

   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Hang guard, generous against the several hundred cycles the tests need
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         finish_test;
      end
   end

   initial
   begin
      {presetn, psel, penable, pwrite, t_sda, arm, stretch} = 7'h00;
      {paddr, tx_byte, pwdata} = 48'h0;
      errors = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd("status", ADDR_STATUS, 32'h8);
      rd("baud", ADDR_BAUD, 32'hA);
      rd("mask", ADDR_IRQ_MASK, 32'h0);
      rd("irq status", ADDR_IRQ_STATUS, 32'h0);
      rd("unmapped", 8'h1C, 32'h0);
      check("slave error", {31'h0, rerr}, 32'h1);
      end_test("reset");
      wr(ADDR_CONFIG, 32'h1);
      wr(ADDR_BAUD, 32'h4);
      rd("baud", ADDR_BAUD, 32'h4);
      // Only the serial event may end the wait; the collision below must not
      wr(ADDR_IRQ_MASK, 32'h1);
      start_rx(8'hA5);
      wr(ADDR_BUFFER, 32'h55);
      wr(ADDR_CONTROL_TWO, 32'h18);
      rd("control busy", ADDR_CONTROL_TWO, 32'h8);
      wait_irq;
      rd("irq status", ADDR_IRQ_STATUS, 32'h5);
      rd("status full", ADDR_STATUS, 32'h9);
      rd("control done", ADDR_CONTROL_TWO, 32'h0);
      check("clock held", {31'h0, scl}, 32'h0);
      wr(ADDR_IRQ_MASK, 32'h0);
      rd("buffer", ADDR_BUFFER, 32'hA5);
      check("irq masked", {31'h0, irq}, 32'h0);
      rd("status read", ADDR_STATUS, 32'h8);
      wr(ADDR_IRQ_STATUS, 32'hF);
      wr(ADDR_IRQ_MASK, 32'hF);
      rd("irq cleared", ADDR_IRQ_STATUS, 32'h0);
      end_test("receive");
      start_rx(8'hC3);
      wait_irq;
      wr(ADDR_IRQ_STATUS, 32'hF);
      start_rx(8'h3C);
      wait_irq;
      rd("overflow", ADDR_IRQ_STATUS, 32'h9);
      rd("buffer", ADDR_BUFFER, 32'h3C);
      wr(ADDR_IRQ_STATUS, 32'hF);
      end_test("overflow");
      stretch <= 1'b1;
      wr(ADDR_CONTROL_TWO, 32'h10);
      repeat (20) @(posedge pclk);
      check("ack waits", {31'h0, irq}, 32'h0);
      check("ack data", {31'h0, sda}, 32'h0);
      stretch <= 1'b0;
      wait_irq;
      rd("ack irq", ADDR_IRQ_STATUS, 32'h1);
      rd("ack control", ADDR_CONTROL_TWO, 32'h0);
      check("data freed", {31'h0, sda}, 32'h1);
      wr(ADDR_IRQ_STATUS, 32'hF);
      wr(ADDR_IRQ_MASK, 32'h1);
      wr(ADDR_CONTROL_TWO, 32'h30);
      t_sda <= 1'b1;
      wr(ADDR_BUFFER, 32'h77);
      wait_irq;
      t_sda <= 1'b0;
      rd("nack irq", ADDR_IRQ_STATUS, 32'h7);
      rd("buffer kept", ADDR_BUFFER, 32'h3C);
      wr(ADDR_IRQ_STATUS, 32'hF);
      wr(ADDR_IRQ_MASK, 32'hF);
      end_test("ack");
      wr(ADDR_CONFIG, 32'h0);
      wr(ADDR_CONFIG, 32'h1);
      t_sda <= 1'b1;
      repeat (8) @(posedge pclk);
      rd("start seen", ADDR_STATUS, 32'h2);
      rd("start irq", ADDR_IRQ_STATUS, 32'h1);
      wr(ADDR_IRQ_STATUS, 32'hF);
      t_sda <= 1'b0;
      repeat (8) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("stop seen", rdata & 32'hC, 32'hC);
      check("stop irq", {31'h0, irq}, 32'h1);
      wr(ADDR_CONFIG, 32'h0);
      rd("disabled", ADDR_STATUS, 32'h8);
      end_test("bus events");
      finish_test;
   end
endmodule
